// ### hdl/dlih_apb_regs.sv
/*
  APB slave of the instruction handler: control, status, pointer and key
  registers. Zero wait states; read data captured in the setup phase.
  Assumes a standard APB master on pclk.
*/
`timescale 1ns/1ps
`include "dlih_params.svh"
module dlih_apb_regs
  import dlih_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] gt_q,
  input wire logic [31:0] status_q,
  input wire logic [23:0] ptr_q,
  input wire logic [63:0] key_q,
  output logic ctrl_wr,
  output logic [2:0] ctrl_wdata
);

  dlih_apb_t s_ff;
  dlih_apb_t nxt_s;
  logic hit;
  logic [31:0] rd;

  always_comb begin
    hit = 1'b1;
    rd = 32'h0;
    unique case (paddr)
      `DLIH_APB_CTRL: rd = {29'h0, gt_q};
      `DLIH_APB_STATUS: rd = status_q;
      `DLIH_APB_POINTER: rd = {8'h0, ptr_q};
      `DLIH_APB_KEY_LO: rd = key_q[31:0];
      `DLIH_APB_KEY_HI: rd = key_q[63:32];
      default: hit = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = s_ff.prdata;
  assign ctrl_wr = psel && penable && pwrite && (paddr == `DLIH_APB_CTRL);
  assign ctrl_wdata = pwdata[2:0];

  always_comb begin
    nxt_s = s_ff;
    if (psel && !penable) begin
      nxt_s.prdata = pwrite ? 32'h0 : rd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule

// ### hdl/dlih_guard_timer.sv
/*
  Turnaround guard timer: counts idle bits of one bit period each.
  Assumes bit_cycles comes from the link's baud logic.
*/
`timescale 1ns/1ps
module dlih_guard_timer
  import dlih_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] gt_bits,
  input wire logic [15:0] bit_cycles,
  output logic done
);

  dlih_guard_t s_ff;
  dlih_guard_t nxt_s;
  logic [18:0] target;

  assign target = 19'(gt_bits) * 19'(bit_cycles);
  assign done = run && (s_ff.cnt >= target);

  always_comb begin
    nxt_s = s_ff;
    if (!run) begin
      nxt_s.cnt = 19'h0;
    end else if (!done) begin
      nxt_s.cnt = s_ff.cnt + 19'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule

// ### hdl/dlih_params.svh
/*
  Constants of the debug link instruction handler: instruction byte layout,
  characters, control space indices, APB offsets and reset values.
  Assumes inclusion by bare name from the handler's design files.
*/
`ifndef DLIH_PARAMS_SVH
`define DLIH_PARAMS_SVH

// Instruction byte fields
`define DLIH_OP_MSB 7
`define DLIH_OP_LSB 5
`define DLIH_PM_MSB 3
`define DLIH_PM_LSB 2
`define DLIH_SZ_MSB 1
`define DLIH_SZ_LSB 0
`define DLIH_SIB_BIT 2
`define DLIH_CSA_MSB 3

// Opcodes
`define DLIH_OP_DLOAD 3'h0
`define DLIH_OP_PLOAD 3'h1
`define DLIH_OP_DSTORE 3'h2
`define DLIH_OP_PSTORE 3'h3
`define DLIH_OP_CSLOAD 3'h4
`define DLIH_OP_REPEAT 3'h5
`define DLIH_OP_CSSTORE 3'h6
`define DLIH_OP_KEY 3'h7

// Pointer modes
`define DLIH_PM_SAME 2'h0
`define DLIH_PM_INC 2'h1
`define DLIH_PM_PTR 2'h2

// Characters
`define DLIH_SYNC_CHAR 8'h55
`define DLIH_ACK_CHAR 8'h40

// Control space indices
`define DLIH_CS_STATUS 4'h0
`define DLIH_CS_CTRL 4'h1
`define DLIH_CS_ERRSIG 4'h2

// Error signatures
`define DLIH_SIG_NONE 3'h0
`define DLIH_SIG_PHY 3'h1
`define DLIH_SIG_FRAME 3'h2
`define DLIH_SIG_INSTR 3'h3
`define DLIH_SIG_BUS 3'h4

// APB byte offsets
`define DLIH_APB_CTRL 8'h00
`define DLIH_APB_STATUS 8'h04
`define DLIH_APB_POINTER 8'h08
`define DLIH_APB_KEY_LO 8'h0C
`define DLIH_APB_KEY_HI 8'h10

// Reset values
`define DLIH_GT_RST 3'h2

`endif

// ### hdl/dlih_pkg.sv
/*
  Types of the debug link instruction handler: state enum, system bus
  carriers and the handler's state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dlih_pkg;

  typedef enum logic [2:0] {
    S_SYNC, S_INS, S_EXEC, S_RX, S_BUS, S_GUARD, S_TX, S_ERR
  } dlih_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [7:0] wdata;
  } dlih_sysreq_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [7:0] rdata;
  } dlih_sysrsp_t;

  typedef struct packed {
    dlih_state_t st;
    logic [7:0] ins;
    logic [4:0] cnt;
    logic [4:0] idx;
    logic [127:0] dbuf;
    logic [63:0] key;
    logic [23:0] ptr;
    logic [7:0] rpt;
    logic first;
    logic [2:0] gt;
    logic err;
    logic [2:0] sig;
    dlih_sysreq_t bus;
  } dlih_core_t;

  typedef struct packed {
    logic [31:0] prdata;
  } dlih_apb_t;

  typedef struct packed {
    logic [18:0] cnt;
  } dlih_guard_t;

endpackage

// ### hdl/dlih_top.sv
/*
  Instruction handler of a single-wire debug link: pointer load/store,
  control space load/store, repeat and key / system info block readout.
  Assumes a byte-level UART front end (sync, break, error detection and
  bit timing outside), a byte-wide system bus and an APB master.
*/
`timescale 1ns/1ps
`include "dlih_params.svh"
module dlih_top
  import dlih_pkg::*;
#(
  // Arbitrary info block contents
  parameter logic [127:0] SIB_DATA = 128'h30313233343536373839414243444546
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_break,
  input wire logic rx_err,
  input wire logic [15:0] bit_cycles,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output dlih_sysreq_t sys_req,
  input dlih_sysrsp_t sys_rsp
);

  dlih_core_t s_ff;
  dlih_core_t nxt_s;
  logic [2:0] op;
  logic [1:0] pm;
  logic [1:0] sz;
  logic fin;
  logic err_now;
  logic [2:0] err_sig;
  logic gdone;
  logic ctrl_wr;
  logic [2:0] ctrl_wdata;
  logic [7:0] cs_rd;
  logic [31:0] status_q;
  logic last;

  // Byte counts of the size fields
  function automatic logic [4:0] addr_bytes(input logic [1:0] f);
    unique case (f)
      2'h0: addr_bytes = 5'd1;
      2'h1: addr_bytes = 5'd2;
      2'h2: addr_bytes = 5'd3;
      default: addr_bytes = 5'd0;
    endcase
  endfunction

  function automatic logic [4:0] data_bytes(input logic [1:0] f);
    unique case (f)
      2'h0: data_bytes = 5'd1;
      2'h1: data_bytes = 5'd2;
      2'h2: data_bytes = 5'd4;
      default: data_bytes = 5'd0;
    endcase
  endfunction

  // Instruction fields
  assign op = s_ff.ins[`DLIH_OP_MSB:`DLIH_OP_LSB];
  assign pm = s_ff.ins[`DLIH_PM_MSB:`DLIH_PM_LSB];
  assign sz = s_ff.ins[`DLIH_SZ_MSB:`DLIH_SZ_LSB];
  assign last = (s_ff.idx == s_ff.cnt - 5'd1);

  assign status_q = {16'h0, s_ff.rpt, 1'b0, s_ff.sig, s_ff.st != S_SYNC, 2'b00, s_ff.err};

  // Control space read port
  always_comb begin
    unique case (s_ff.ins[`DLIH_CSA_MSB:0])
      `DLIH_CS_STATUS: cs_rd = {7'h0, s_ff.err};
      `DLIH_CS_CTRL: cs_rd = {5'h0, s_ff.gt};
      `DLIH_CS_ERRSIG: cs_rd = {5'h0, s_ff.sig};
      default: cs_rd = 8'h0;
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    fin = 1'b0;
    err_now = 1'b0;
    err_sig = `DLIH_SIG_NONE;
    if (ctrl_wr) begin
      nxt_s.gt = ctrl_wdata;
    end
    if (rx_break) begin
      // Break is the only exit from error; it also clears a pending repeat
      nxt_s.st = S_SYNC;
      nxt_s.rpt = 8'h0;
      nxt_s.err = 1'b0;
      nxt_s.bus.req = 1'b0;
      err_now = rx_err;
      err_sig = `DLIH_SIG_PHY;
    end else if (rx_err && s_ff.st != S_ERR) begin
      err_now = 1'b1;
      err_sig = `DLIH_SIG_PHY;
    end else begin
      unique case (s_ff.st)
        S_SYNC: begin
          if (rx_valid) begin
            if (rx_data == `DLIH_SYNC_CHAR) begin
              nxt_s.st = S_INS;
            end else begin
              err_now = 1'b1;
              err_sig = `DLIH_SIG_FRAME;
            end
          end
        end
        S_INS: begin
          if (rx_valid) begin
            nxt_s.ins = rx_data;
            nxt_s.first = 1'b1;
            nxt_s.st = S_EXEC;
          end
        end
        S_EXEC: begin
          nxt_s.idx = 5'h0;
          unique case (op)
            `DLIH_OP_PLOAD: begin
              nxt_s.cnt = data_bytes(sz);
              if (sz == 2'h3 || pm == 2'h3) begin
                err_now = 1'b1;
                err_sig = `DLIH_SIG_INSTR;
              end else if (pm == `DLIH_PM_PTR) begin
                nxt_s.dbuf = {104'h0, s_ff.ptr};
                nxt_s.st = s_ff.first ? S_GUARD : S_TX;
              end else begin
                nxt_s.st = S_BUS;
              end
            end
            `DLIH_OP_PSTORE: begin
              if (sz == 2'h3 || pm == 2'h3) begin
                err_now = 1'b1;
                err_sig = `DLIH_SIG_INSTR;
              end else if (pm == `DLIH_PM_PTR) begin
                nxt_s.cnt = addr_bytes(sz);
                nxt_s.ptr = 24'h0;
                nxt_s.st = S_RX;
              end else begin
                nxt_s.cnt = data_bytes(sz);
                nxt_s.st = S_RX;
              end
            end
            `DLIH_OP_CSLOAD: begin
              nxt_s.dbuf = {120'h0, cs_rd};
              nxt_s.cnt = 5'd1;
              nxt_s.st = s_ff.first ? S_GUARD : S_TX;
            end
            `DLIH_OP_CSSTORE: begin
              nxt_s.cnt = 5'd1;
              nxt_s.st = S_RX;
            end
            `DLIH_OP_REPEAT: begin
              if (sz[1]) begin
                err_now = 1'b1;
                err_sig = `DLIH_SIG_INSTR;
              end else begin
                nxt_s.cnt = sz[0] ? 5'd2 : 5'd1;
                nxt_s.st = S_RX;
              end
            end
            `DLIH_OP_KEY: begin
              if (s_ff.ins[`DLIH_SIB_BIT] && !sz[1]) begin
                nxt_s.dbuf = SIB_DATA;
                nxt_s.cnt = sz[0] ? 5'd16 : 5'd8;
                nxt_s.st = s_ff.first ? S_GUARD : S_TX;
              end else if (!s_ff.ins[`DLIH_SIB_BIT] && sz == 2'h0) begin
                nxt_s.cnt = 5'd8;
                nxt_s.st = S_RX;
              end else begin
                err_now = 1'b1;
                err_sig = `DLIH_SIG_INSTR;
              end
            end
            default: begin
              err_now = 1'b1;
              err_sig = `DLIH_SIG_INSTR;
            end
          endcase
        end
        S_RX: begin
          if (rx_valid) begin
            nxt_s.idx = s_ff.idx + 5'd1;
            unique case (op)
              `DLIH_OP_PSTORE: begin
                if (pm == `DLIH_PM_PTR) begin
                  nxt_s.ptr[{s_ff.idx[1:0], 3'b000} +: 8] = rx_data;
                end else begin
                  nxt_s.dbuf[{s_ff.idx[3:0], 3'b000} +: 8] = rx_data;
                end
              end
              `DLIH_OP_CSSTORE: begin
                if (s_ff.ins[`DLIH_CSA_MSB:0] == `DLIH_CS_CTRL) begin
                  nxt_s.gt = rx_data[2:0];
                end
              end
              `DLIH_OP_REPEAT: begin
                if (s_ff.idx == 5'h0) begin
                  nxt_s.rpt = rx_data;
                end
              end
              default: begin
                nxt_s.dbuf[{s_ff.idx[3:0], 3'b000} +: 8] = rx_data;
              end
            endcase
            if (last) begin
              nxt_s.idx = 5'h0;
              unique case (op)
                `DLIH_OP_PSTORE: begin
                  if (pm == `DLIH_PM_PTR) begin
                    nxt_s.dbuf = {120'h0, `DLIH_ACK_CHAR};
                    nxt_s.cnt = 5'd1;
                    nxt_s.st = S_GUARD;
                  end else begin
                    nxt_s.st = S_BUS;
                  end
                end
                `DLIH_OP_REPEAT: nxt_s.st = S_SYNC;
                `DLIH_OP_KEY: begin
                  nxt_s.key = nxt_s.dbuf[63:0];
                  fin = 1'b1;
                end
                default: fin = 1'b1;
              endcase
            end
          end
        end
        S_BUS: begin
          if (!s_ff.bus.req) begin
            nxt_s.bus.req = 1'b1;
            nxt_s.bus.we = (op == `DLIH_OP_PSTORE);
            nxt_s.bus.addr = s_ff.ptr + {19'h0, s_ff.idx};
            nxt_s.bus.wdata = s_ff.dbuf[{s_ff.idx[3:0], 3'b000} +: 8];
          end else if (sys_rsp.err) begin
            err_now = 1'b1;
            err_sig = `DLIH_SIG_BUS;
          end else if (sys_rsp.ack) begin
            nxt_s.bus.req = 1'b0;
            nxt_s.idx = s_ff.idx + 5'd1;
            if (!s_ff.bus.we) begin
              nxt_s.dbuf[{s_ff.idx[3:0], 3'b000} +: 8] = sys_rsp.rdata;
            end
            if (last) begin
              nxt_s.idx = 5'h0;
              if (s_ff.bus.we) begin
                if (pm == `DLIH_PM_INC) begin
                  nxt_s.ptr = s_ff.ptr + {19'h0, s_ff.cnt};
                end
                nxt_s.dbuf = {120'h0, `DLIH_ACK_CHAR};
                nxt_s.cnt = 5'd1;
                nxt_s.st = S_GUARD;
              end else begin
                nxt_s.st = s_ff.first ? S_GUARD : S_TX;
              end
            end
          end
        end
        S_GUARD: begin
          if (gdone) begin
            nxt_s.st = S_TX;
          end
        end
        S_TX: begin
          if (tx_ready) begin
            nxt_s.dbuf = s_ff.dbuf >> 8;
            nxt_s.idx = s_ff.idx + 5'd1;
            if (last) begin
              nxt_s.idx = 5'h0;
              fin = 1'b1;
            end
          end
        end
        S_ERR: begin
          nxt_s.st = S_ERR;
        end
        default: begin
          nxt_s.st = S_SYNC;
        end
      endcase
    end
    if (fin) begin
      if (op == `DLIH_OP_PLOAD && pm == `DLIH_PM_INC) begin
        nxt_s.ptr = s_ff.ptr + {19'h0, s_ff.cnt};
      end
      if (s_ff.rpt != 8'h0) begin
        nxt_s.rpt = s_ff.rpt - 8'h1;
        nxt_s.first = 1'b0;
        nxt_s.st = S_EXEC;
      end else begin
        nxt_s.st = S_SYNC;
      end
    end
    if (err_now) begin
      nxt_s.st = S_ERR;
      nxt_s.err = 1'b1;
      nxt_s.sig = err_sig;
      nxt_s.bus.req = 1'b0;
      nxt_s.rpt = 8'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{st: S_SYNC, gt: `DLIH_GT_RST, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tx_valid = (s_ff.st == S_TX);
  assign tx_data = s_ff.dbuf[7:0];
  assign sys_req = s_ff.bus;

  dlih_guard_timer u_guard (
    .pclk(pclk),
    .presetn(presetn),
    .run(s_ff.st == S_GUARD),
    .gt_bits(s_ff.gt),
    .bit_cycles(bit_cycles),
    .done(gdone)
  );

  dlih_apb_regs u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .gt_q(s_ff.gt),
    .status_q(status_q),
    .ptr_q(s_ff.ptr),
    .key_q(s_ff.key),
    .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata)
  );

endmodule

// ### verification/dlih_sys_mem.sv
/*
  System bus memory model: 256 bytes, set answer delay, error on command.
  Assumes the handler's byte-wide request held until answered.
*/
`timescale 1ns/1ps
module dlih_sys_mem
  import dlih_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lat,
  input wire logic fail,
  input dlih_sysreq_t sys_req,
  output dlih_sysrsp_t sys_rsp
);
  logic [7:0] m [256];
  logic [3:0] wait_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_rsp <= '0;
      wait_ff <= 4'h0;
    end else begin
      sys_rsp.ack <= 1'b0;
      sys_rsp.err <= 1'b0;
      sys_rsp.rdata <= ~sys_rsp.rdata;
      if (sys_req.req && !sys_rsp.ack && !sys_rsp.err) begin
        wait_ff <= wait_ff + 4'h1;
        if (wait_ff >= lat) begin
          wait_ff <= 4'h0;
          sys_rsp.err <= fail;
          sys_rsp.ack <= !fail;
          if (sys_req.we && !fail) m[sys_req.addr[7:0]] <= sys_req.wdata;
          else sys_rsp.rdata <= m[sys_req.addr[7:0]];
        end
      end
    end
  end
endmodule

// ### verification/dlih_top_monitor.sv
/*
  Port checker of the instruction handler.
  Assumes one clock and an async active-low reset.
*/
`timescale 1ns/1ps
module dlih_mon
  import dlih_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic rx_break,
  input wire logic rx_err,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input dlih_sysreq_t sys_req,
  input dlih_sysrsp_t sys_rsp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lock(ev);
    ev |=> (!tx_valid && !sys_req.req) until rx_break;
  endproperty
  a_req_hold: assert property (sys_req.req && !sys_rsp.ack && !sys_rsp.err
    |=> sys_req.req && $stable(sys_req)) else $error("bus request changed early");
  a_req_gap: assert property (sys_rsp.ack |=> !sys_req.req)
    else $error("bus request kept after answer");
  a_req_fall: assert property ($fell(sys_req.req)
    |-> $past(sys_rsp.ack) || $past(sys_rsp.err)) else $error("bus request left unanswered");
  a_tx_hold: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_data)) else $error("response byte not held");
  a_turn_gap: assert property (rx_valid |=> !tx_valid [*2])
    else $error("response without turnaround");
  a_err_lock: assert property (p_lock(rx_err))
    else $error("activity in error state");
  a_bus_lock: assert property (p_lock(sys_rsp.err))
    else $error("activity after bus error");
  a_ready_up: assert property (pready) else $error("pready low");
  a_bad_addr: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  c_store: cover property (sys_rsp.ack && sys_req.we);
  c_stall: cover property (tx_valid && !tx_ready);
  c_break: cover property (rx_break);
endmodule
bind dlih_top dlih_mon u_mon (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .rx_valid, .rx_break, .rx_err, .tx_valid, .tx_data, .tx_ready, .sys_req, .sys_rsp);

// ### verification/tb.sv
/*
  Self-checking bench: APB and link drivers, expectation queues, monitor.
  Assumes dlih_sys_mem answers the system bus.
*/
`timescale 1ns/1ps
`include "dlih_params.svh"
`define CHK(n, e, g) chk(n, 64'(e), 64'(g))
module tb;
  import dlih_pkg::*;
  localparam logic [127:0] SIB_V = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fail = 0, txp = 0;
  logic pready, pslverr, rx_valid = 0, rx_break = 0, rx_err = 0, tx_valid, tx_ready = 0;
  logic [7:0] paddr = 0, rx_data = 0, tx_data;
  logic [31:0] pwdata = 0, prdata, seed = 32'h34CA58EC;
  logic [15:0] bit_cycles = 16'h4, gap = 0;
  logic [3:0] lat = 0;
  logic [23:0] p;
  logic [63:0] k;
  int fail_count = 0, cmp_count = 0, gt = 2;
  logic [7:0] exp_tx[$], d[$];
  logic [32:0] exp_rd[$];
  dlih_sysreq_t sys_req;
  dlih_sysrsp_t sys_rsp;
  dlih_top #(.SIB_DATA(SIB_V)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_break, .rx_err,
    .bit_cycles, .tx_valid, .tx_data, .tx_ready, .sys_req, .sys_rsp);
  dlih_sys_mem mem (.pclk, .presetn, .lat, .fail, .sys_req, .sys_rsp);
  initial forever #5 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (e !== g) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic er);
    exp_rd.push_back({er, v});
    apb(0, a, 32'h0);
  endtask
  task automatic snd(input logic [7:0] b);
    @(posedge pclk);
    rx_valid <= 1;
    rx_data <= b;
    @(posedge pclk);
    rx_valid <= 0;
    rx_data <= ~b;
    repeat (6) @(posedge pclk);
  endtask
  task automatic sndv(input logic [127:0] v, input int n);
    for (int i = 0; i < n; i++) snd(v[8*i +: 8]);
  endtask
  task automatic expv(input logic [127:0] v, input int n);
    for (int i = 0; i < n; i++) exp_tx.push_back(v[8*i +: 8]);
  endtask
  task automatic frame(input logic [2:0] op, input logic [1:0] pm, input logic [1:0] sz);
    snd(`DLIH_SYNC_CHAR);
    snd({op, 1'b0, pm, sz});
  endtask
  task automatic wait_rsp();
    for (int i = 0; i < 3000 && exp_tx.size() > 0; i++) @(posedge pclk);
    `CHK("pending", 0, exp_tx.size());
    repeat (4) @(posedge pclk);
  endtask
  task automatic setp(input logic [23:0] a, input logic [1:0] s);
    exp_tx.push_back(`DLIH_ACK_CHAR);
    frame(`DLIH_OP_PSTORE, `DLIH_PM_PTR, s);
    sndv(128'(a), s + 1);
    wait_rsp();
  endtask
  task automatic rep(input logic [7:0] n);
    frame(`DLIH_OP_REPEAT, 2'h0, 2'h0);
    snd(n);
  endtask
  task automatic stores(input int blocks, input int nb);
    for (int b = 0; b < blocks; b++) begin
      exp_tx.push_back(`DLIH_ACK_CHAR);
      for (int i = 0; i < nb; i++) begin
        d.push_back(8'(rnd()));
        snd(d[$]);
      end
      wait_rsp();
    end
  endtask
  task automatic brk();
    rx_break <= 1;
    fail <= 0;
    @(posedge pclk);
    rx_break <= 0;
  endtask
  task automatic cs_read(input logic [3:0] a, input logic [7:0] v);
    exp_tx.push_back(v);
    frame(`DLIH_OP_CSLOAD, a[3:2], a[1:0]);
    wait_rsp();
  endtask
  always @(posedge pclk) begin
    tx_ready <= ^rnd();
    gap <= rx_valid ? 16'h0 : gap + 16'h1;
    txp <= tx_valid;
    if (tx_valid && !txp) `CHK("guard", 1'b1, gap >= gt * bit_cycles);
    if (tx_valid && tx_ready) begin
      if (exp_tx.size() > 0) `CHK("tx_data", exp_tx.pop_front(), tx_data);
      else `CHK("tx_extra", 1'b0, 1'b1);
    end
    if (psel && penable && pready && !pwrite) `CHK("prdata", exp_rd.pop_front(), {pslverr, prdata});
  end
  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    conclude();
  end
  initial begin
    for (int i = 0; i < 256; i++) mem.m[i] = 8'(rnd());
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(`DLIH_APB_CTRL, 32'h2, 0);
    rd(8'h14, 32'h0, 1);
    apb(1, `DLIH_APB_CTRL, 32'h3);
    rd(`DLIH_APB_CTRL, 32'h3, 0);
    $display("test apb done");
    for (int g = 0; g < 4; g++) begin
      frame(`DLIH_OP_CSSTORE, 2'h0, 2'h1);
      snd(8'(g));
      gt = g;
      cs_read(`DLIH_CS_CTRL, 8'(g));
    end
    $display("test control space done");
    for (int s = 0; s < 3; s++) begin
      p = 24'(rnd()) & ~(24'hFFFFFF << (8 * s + 8));
      setp(p, 2'(s));
      rd(`DLIH_APB_POINTER, 32'(p), 0);
      expv(128'(p), 4);
      frame(`DLIH_OP_PLOAD, `DLIH_PM_PTR, 2'h2);
      wait_rsp();
    end
    $display("test pointer done");
    lat <= 4'h3;
    setp(24'h10, 2'h0);
    rep(8'h2);
    frame(`DLIH_OP_PSTORE, `DLIH_PM_INC, 2'h1);
    stores(3, 2);
    for (int i = 0; i < 6; i++) `CHK("mem", d[i], mem.m[16 + i]);
    rd(`DLIH_APB_POINTER, 32'h16, 0);
    setp(24'h10, 2'h0);
    rep(8'h2);
    foreach (d[i]) exp_tx.push_back(d[i]);
    frame(`DLIH_OP_PLOAD, `DLIH_PM_INC, 2'h1);
    wait_rsp();
    d.delete();
    setp(24'h30, 2'h0);
    frame(`DLIH_OP_REPEAT, 2'h0, 2'h1);
    sndv(128'h1, 2);
    frame(`DLIH_OP_PSTORE, `DLIH_PM_SAME, 2'h0);
    stores(2, 1);
    `CHK("same", d[1], mem.m[8'h30]);
    rd(`DLIH_APB_POINTER, 32'h30, 0);
    $display("test repeat done");
    k = {rnd(), rnd()};
    frame(`DLIH_OP_KEY, 2'h0, 2'h0);
    sndv(128'(k), 8);
    rd(`DLIH_APB_KEY_LO, k[31:0], 0);
    rd(`DLIH_APB_KEY_HI, k[63:32], 0);
    for (int s = 0; s < 2; s++) begin
      expv(SIB_V, 8 << s);
      frame(`DLIH_OP_KEY, 2'h1, 2'(s));
      wait_rsp();
    end
    $display("test key done");
    for (int e = 1; e < 5; e++) begin
      case (e)
        1: begin
          rx_err <= 1;
          @(posedge pclk);
          rx_err <= 0;
        end
        2: snd(8'h00);
        3: frame(`DLIH_OP_PSTORE, `DLIH_PM_PTR, 2'h3);
        default: begin
          fail <= 1;
          frame(`DLIH_OP_PSTORE, `DLIH_PM_SAME, 2'h0);
          snd(8'hA5);
        end
      endcase
      frame(`DLIH_OP_CSLOAD, 2'h0, 2'h0);
      repeat (40) @(posedge pclk);
      brk();
      cs_read(`DLIH_CS_ERRSIG, 8'(e));
      cs_read(`DLIH_CS_STATUS, 8'h0);
    end
    rep(8'h3);
    frame(`DLIH_OP_PSTORE, `DLIH_PM_INC, 2'h0);
    stores(1, 1);
    brk();
    cs_read(`DLIH_CS_STATUS, 8'h0);
    $display("test errors done");
    conclude();
  end
endmodule
